// File: common/svd_pkg.sv
// package: constants and types for the supply voltage detector control
package svd_pkg;

  localparam logic [19:0] SVD_ADDR_CTRL  = 20'hfffa9;
  localparam logic [19:0] SVD_ADDR_LEVEL = 20'hfffaa;
  localparam logic [7:0]  SVD_CFG_ADDR   = 8'hc1;

  localparam int SVD_CTRL_WEN_BIT  = 7;
  localparam int SVD_CTRL_MASK_BIT = 1;
  localparam int SVD_CTRL_FLAG_BIT = 0;
  localparam int SVD_LVL_MODE_BIT  = 7;
  localparam int SVD_LVL_THR_BIT   = 0;

  localparam logic [7:0] SVD_CTRL_RST      = 8'h00;
  localparam logic [7:0] SVD_LVL_RST_INTRS = 8'h00;
  localparam logic [7:0] SVD_LVL_RST_RESET = 8'h81;
  localparam logic [7:0] SVD_LVL_RST_INT   = 8'h01;

  localparam logic [2:0] SVD_RANGE_INTRS = 3'h3;

  // settling wait, in microseconds, and its cycle count at 25 mhz
  localparam int SVD_CLK_MHZ     = 25;
  localparam int SVD_SETTLE_US   = 400;
  localparam int SVD_SETTLE_CYC  = SVD_SETTLE_US * SVD_CLK_MHZ;

  typedef enum logic [1:0] {
    SVD_MODE_OFF   = 2'h0,
    SVD_MODE_INT   = 2'h1,
    SVD_MODE_INTRS = 2'h2,
    SVD_MODE_RESET = 2'h3
  } svd_mode_t;

  typedef struct packed {
    logic [2:0] range_code;
    logic       fixed_one;
    logic [1:0] fine_code;
    logic [1:0] mode_code;
  } svd_cfg_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [7:0] bitmask;
  } svd_bus_t;

  typedef struct packed {
    logic high_below;
    logic low_below;
  } svd_cmp_t;

  // mode decode, used for reset loading and for behaviour
  function automatic svd_mode_t svd_decode(input svd_cfg_t c);
    if (c.range_code[2] && c.mode_code[0])
      return SVD_MODE_OFF;
    unique case (c.mode_code)
      2'h1:    return SVD_MODE_INT;
      2'h2:    return SVD_MODE_INTRS;
      2'h3:    return SVD_MODE_RESET;
      default: return SVD_MODE_OFF;
    endcase
  endfunction : svd_decode

  // prohibited combinations leave the detector inert, except in reset mode, which holds reset
  function automatic logic svd_cfg_ok(input svd_cfg_t c);
    logic [4:0] rf;
    rf = {c.range_code, c.fine_code};
    if (!c.fixed_one)
      return 1'b0;
    unique case (c.mode_code)
      2'h2: return (c.range_code == SVD_RANGE_INTRS) && (c.fine_code != 2'h3);
      default:
        return (rf == 5'h0f) || (rf == 5'h0e) || (rf == 5'h0d) || (rf == 5'h04)
            || (rf == 5'h08) || (rf == 5'h0c) || (rf == 5'h1c) || c.range_code[2];
    endcase
  endfunction : svd_cfg_ok

endpackage : svd_pkg

// File: core/svd_ctrl.sv
// supply voltage detector control: registers, mode decode, reset and irq
//
// How it works
// - non-detector resets clear control register; detector reset keeps it
// - control bits 1 and 0 are read-only; writes ignored
// - bit 7 enables level writes and masks detector reset and irq
// - control bit 1 shows whether detector output is masked
// - control bit 0 is one while supply is below threshold with detector on and a valid config, else zero
// - mask forced in interrupt-and-reset mode: enable, post-irq, post-level-change settle
// - level bit 7 mode, bit 0 threshold; other bits read zero
// - level register kept on detector reset, else loaded 00/81/01 by mode
// - interrupt-and-reset mode: hardware sets level bits on detector reset or irq
// - mode code decode; range bit 2 with mode bit 0 means off
// - interrupt-and-reset mode allows range 011 with fine 10, 01, 00
// - reset and interrupt modes allow six single-threshold combinations
// - reset mode starts with enable zero and level register 81h
// - reset mode releases reset one clock after power-up and, with supply below threshold, reasserts it four clocks later
// - reset mode asserts reset whenever supply falls below threshold
// - in interrupt-and-reset mode both registers accept single-bit and whole-byte read-modify-write
// - interrupt-and-reset: irq below high threshold, reset below low threshold
// - interrupt mode: irq on each crossing after the reset releases
`timescale 1ns/1ps
module svd_ctrl
  import svd_pkg::*;
#(
  parameter int SETTLE_CYC = svd_pkg::SVD_SETTLE_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              det_rst_i,
  input  wire svd_pkg::svd_cfg_t cfg_i,
  input  wire svd_pkg::svd_bus_t bus_i,
  input  wire svd_pkg::svd_cmp_t cmp_i,
  output logic [7:0]             rdata_o,
  output logic                   int_rst_o,
  output logic                   supply_drop_irq_o,
  output logic                   ext_reset_pin_en_o
);
  import svd_pkg::*;

  typedef enum logic [1:0] {
    SVD_S_IDLE   = 2'h0,
    SVD_S_SETTLE = 2'h1
  } svd_st_t;

  localparam int CW = $clog2(SETTLE_CYC + 1);

  svd_mode_t   mode;
  logic        cfg_valid;
  logic [1:0]  hi_s1_r, hi_s2_r, lo_s1_r, lo_s2_r;
  logic        hi_prev_r, hi_prev_nxt;
  logic        lvl_wen_r, lvl_wen_nxt;
  logic        mode_bit_r, mode_bit_nxt;
  logic        thr_bit_r, thr_bit_nxt;
  logic        flag_r, flag_nxt;
  logic        mask_r, mask_nxt;
  logic        started_r, started_nxt;
  logic        irq_r, irq_nxt;
  logic        rst_out_r, rst_out_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  svd_st_t     st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic        ext_r, ext_nxt;
  logic        hi_below, lo_below, sel_below;
  logic        wr_ctrl, wr_lvl;
  logic [7:0]  ctrl_view, lvl_view, ctrl_w, lvl_w;

  assign mode = svd_decode(cfg_i);
  assign cfg_valid = svd_cfg_ok(cfg_i);

  // two-stage synchronisers of two flops each, last flop of the second stage only is read
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_s1_r <= 2'h0;
      hi_s2_r <= 2'h0;
      lo_s1_r <= 2'h0;
      lo_s2_r <= 2'h0;
    end
    else
    begin
      hi_s1_r <= {hi_s1_r[0], cmp_i.high_below};
      hi_s2_r <= {hi_s2_r[0], hi_s1_r[1]};
      lo_s1_r <= {lo_s1_r[0], cmp_i.low_below};
      lo_s2_r <= {lo_s2_r[0], lo_s1_r[1]};
    end
  end

  assign hi_below  = hi_s2_r[1] && cfg_valid && (mode != SVD_MODE_OFF);
  assign lo_below  = lo_s2_r[1] && cfg_valid && (mode != SVD_MODE_OFF);
  // low bit selects which comparator the flag follows
  assign sel_below = (mode == SVD_MODE_INTRS && !thr_bit_r) ? hi_below : lo_below;

  assign ctrl_view = {lvl_wen_r, 5'h00, mask_r, flag_r};
  assign lvl_view  = {mode_bit_r, 6'h00, thr_bit_r};
  assign wr_ctrl   = bus_i.wr && (bus_i.addr == SVD_ADDR_CTRL);
  assign wr_lvl    = bus_i.wr && (bus_i.addr == SVD_ADDR_LEVEL);
  // bit mask merges single-bit writes into the held byte
  assign ctrl_w    = (ctrl_view & ~bus_i.bitmask) | (bus_i.wdata & bus_i.bitmask);
  assign lvl_w     = (lvl_view & ~bus_i.bitmask) | (bus_i.wdata & bus_i.bitmask);

  always_comb
  begin
    lvl_wen_nxt  = lvl_wen_r;
    mode_bit_nxt = mode_bit_r;
    thr_bit_nxt  = thr_bit_r;
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    hi_prev_nxt  = sel_below;
    started_nxt  = started_r;
    irq_nxt      = 1'b0;
    rst_out_nxt  = 1'b0;
    ext_nxt      = (mode == SVD_MODE_OFF);
    flag_nxt     = sel_below;
    rdata_nxt    = 8'h00;
    if (bus_i.rd && bus_i.addr == SVD_ADDR_CTRL)
      rdata_nxt = ctrl_view;
    else if (bus_i.rd && bus_i.addr == SVD_ADDR_LEVEL)
      rdata_nxt = lvl_view;

    // only enable is writable, and only in interrupt-and-reset mode
    if (wr_ctrl && mode == SVD_MODE_INTRS)
      lvl_wen_nxt = ctrl_w[SVD_CTRL_WEN_BIT];
    if (wr_lvl && lvl_wen_r && mode == SVD_MODE_INTRS)
    begin
      mode_bit_nxt = lvl_w[SVD_LVL_MODE_BIT];
      thr_bit_nxt  = lvl_w[SVD_LVL_THR_BIT];
      // threshold change starts a settle wait
      if (lvl_w[SVD_LVL_THR_BIT] != thr_bit_r)
      begin
        st_nxt  = SVD_S_SETTLE;
        cnt_nxt = CW'(SETTLE_CYC);
      end
    end

    unique case (st_r)
      SVD_S_IDLE:   ;
      SVD_S_SETTLE:
      begin
        if (cnt_r <= CW'(1))
          st_nxt = SVD_S_IDLE;
        else
          cnt_nxt = cnt_r - CW'(1);
      end
    endcase

    unique case (mode)
      SVD_MODE_RESET:
      begin
        rst_out_nxt = lo_below || !cfg_valid;
      end
      SVD_MODE_INT:
      begin
        // irq on either crossing once released
        if (!started_r)
        begin
          rst_out_nxt = lo_below;
          started_nxt = !lo_below;
        end
        else
          irq_nxt = (sel_below != hi_prev_r);
      end
      SVD_MODE_INTRS:
      begin
        if (!started_r)
        begin
          rst_out_nxt = hi_below;
          started_nxt = !hi_below;
        end
        else if (!mask_r)
        begin
          // low threshold resets; reset mode bit also resets below high
          if (lo_below || (mode_bit_r && hi_below))
          begin
            rst_out_nxt  = 1'b1;
            mode_bit_nxt = 1'b1;
            thr_bit_nxt  = 1'b1;
          end
          else if (hi_below && !thr_bit_r)
          begin
            irq_nxt      = 1'b1;
            // switch to low level and settle
            mode_bit_nxt = 1'b1;
            thr_bit_nxt  = 1'b1;
            st_nxt       = SVD_S_SETTLE;
            cnt_nxt      = CW'(SETTLE_CYC);
          end
        end
      end
      default: ;
    endcase

    // mask only in interrupt-and-reset mode
    // taken after the mode case so an irq masks in the same cycle its pulse is high, no reset glitch
    mask_nxt = (mode == SVD_MODE_INTRS) && (lvl_wen_nxt || st_nxt == SVD_S_SETTLE);
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_prev_r <= 1'b0;
      flag_r    <= 1'b0;
      mask_r    <= 1'b0;
      started_r <= 1'b0;
      irq_r     <= 1'b0;
      rst_out_r <= 1'b1;
      rdata_r   <= 8'h00;
      st_r      <= SVD_S_IDLE;
      cnt_r     <= '0;
      ext_r     <= 1'b0;
    end
    else
    begin
      hi_prev_r <= hi_prev_nxt;
      flag_r    <= flag_nxt;
      mask_r    <= mask_nxt;
      started_r <= started_nxt;
      irq_r     <= irq_nxt;
      rst_out_r <= rst_out_nxt;
      rdata_r   <= rdata_nxt;
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      ext_r     <= ext_nxt;
    end
  end

  // register state: reset values depend on the configuration byte,
  // so they are loaded on every clock while reset is low and on the first clock after release, not by the async reset
  logic load_pend_r;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      load_pend_r <= 1'b1;
    else
      load_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (load_pend_r && !det_rst_i)
    begin
      lvl_wen_r  <= SVD_CTRL_RST[SVD_CTRL_WEN_BIT];
      mode_bit_r <= (mode == SVD_MODE_RESET) ? SVD_LVL_RST_RESET[SVD_LVL_MODE_BIT] :
                    (mode == SVD_MODE_INT)   ? SVD_LVL_RST_INT[SVD_LVL_MODE_BIT]   :
                                               SVD_LVL_RST_INTRS[SVD_LVL_MODE_BIT];
      thr_bit_r  <= (mode == SVD_MODE_RESET) ? SVD_LVL_RST_RESET[SVD_LVL_THR_BIT] :
                    (mode == SVD_MODE_INT)   ? SVD_LVL_RST_INT[SVD_LVL_THR_BIT]   :
                                               SVD_LVL_RST_INTRS[SVD_LVL_THR_BIT];
    end
    else if (!load_pend_r)
    begin
      lvl_wen_r  <= lvl_wen_nxt;
      mode_bit_r <= mode_bit_nxt;
      thr_bit_r  <= thr_bit_nxt;
    end
    // detector reset keeps the held values
  end

  assign rdata_o            = rdata_r;
  assign int_rst_o          = rst_out_r;
  assign supply_drop_irq_o  = irq_r;
  assign ext_reset_pin_en_o = ext_r;

endmodule : svd_ctrl

// File: verif/svd_ctrl_sva.sv
// checker: port-level assertions for the detector control
`timescale 1ns/1ps
module svd_ctrl_sva
  import svd_pkg::*;
#(
  parameter int SETTLE_CYC = svd_pkg::SVD_SETTLE_CYC
) (
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire svd_pkg::svd_cfg_t cfg_i,
  input wire svd_pkg::svd_bus_t bus_i,
  input wire svd_pkg::svd_cmp_t cmp_i,
  input wire logic [7:0]        rdata_o,
  input wire logic              int_rst_o,
  input wire logic              supply_drop_irq_o,
  input wire logic              ext_reset_pin_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic rmode;
  logic imode;
  logic both_lo;
  logic both_hi;
  assign rmode = (cfg_i.mode_code == 2'h3) && !cfg_i.range_code[2];
  assign imode = (cfg_i.mode_code == 2'h1) && !cfg_i.range_code[2];
  assign both_lo = cmp_i.low_below && cmp_i.high_below;
  assign both_hi = !cmp_i.low_below && !cmp_i.high_below;
  idle_read_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data not zero when idle");
  ctrl_fixed_a: assert property ($past(bus_i.rd && bus_i.addr == SVD_ADDR_CTRL)
    |-> rdata_o[6:2] == 5'h00)
    else $error("control unused bits not zero");
  level_fixed_a: assert property ($past(bus_i.rd && bus_i.addr == SVD_ADDR_LEVEL)
    |-> rdata_o[6:1] == 6'h00)
    else $error("level unused bits not zero");
  off_decode_a: assert property ($past(rst_b_i)
    |-> ext_reset_pin_en_o == (cfg_i.range_code[2] && cfg_i.mode_code[0]))
    else $error("detector off decode wrong");
  irq_pulse_a: assert property (supply_drop_irq_o |=> !supply_drop_irq_o)
    else $error("irq longer than one cycle");
  reset_no_irq_a: assert property (rmode |-> !supply_drop_irq_o)
    else $error("irq in reset mode");
  drop_reset_a: assert property ((rmode && both_lo) [*7] |-> int_rst_o)
    else $error("no reset with supply low");
  rise_release_a: assert property ((rmode && both_hi) [*7] |-> !int_rst_o)
    else $error("reset held with supply high");
  int_release_a: assert property ((imode && both_hi) [*7] |-> !int_rst_o)
    else $error("interrupt mode reset held");
  irq_mask_a: assert property (supply_drop_irq_o |=> !int_rst_o)
    else $error("reset right after irq");
endmodule : svd_ctrl_sva

bind svd_ctrl svd_ctrl_sva #(.SETTLE_CYC(SETTLE_CYC)) u_svd_ctrl_sva (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_i(cfg_i), .bus_i(bus_i), .cmp_i(cmp_i),
  .rdata_o(rdata_o), .int_rst_o(int_rst_o), .supply_drop_irq_o(supply_drop_irq_o),
  .ext_reset_pin_en_o(ext_reset_pin_en_o));

// File: verif/svd_supply_model.sv
// model: analog supply comparators in front of the detector control
`timescale 1ns/1ps
module svd_supply_model
  import svd_pkg::*;
#(
  parameter int HIGH_MV = 2920,
  parameter int LOW_MV  = 2750
) (
  input  wire logic [15:0]     vdd_mv_i,
  output svd_pkg::svd_cmp_t    cmp_o
);
  assign cmp_o.high_below = (vdd_mv_i < 16'(HIGH_MV));
  assign cmp_o.low_below  = (vdd_mv_i < 16'(LOW_MV));
endmodule : svd_supply_model

// File: verif/tb_top.sv
// testbench: register accesses and supply sweeps in every mode
`timescale 1ns/1ps
module tb_top;
  import svd_pkg::*;
  logic       clk_i;
  logic       rst_b_i;
  logic       det_rst_i;
  logic       int_rst;
  logic       irq;
  logic       ext;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [15:0] vdd;
  svd_cfg_t   cfg;
  svd_bus_t   bus;
  svd_cmp_t   cmp;
  int         mismatches;
  int         n_tests;

  svd_supply_model u_svd_supply_model (.vdd_mv_i(vdd), .cmp_o(cmp));
  svd_ctrl #(.SETTLE_CYC(8)) u_svd_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .det_rst_i(det_rst_i), .cfg_i(cfg), .bus_i(bus), .cmp_i(cmp), .rdata_o(rdata),
    .int_rst_o(int_rst), .supply_drop_irq_o(irq), .ext_reset_pin_en_o(ext));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [7:0] v, input logic [7:0] m);
    @(negedge clk_i);
    bus = '{1'b0, 1'b1, a, v, m};
    @(negedge clk_i);
    bus.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [19:0] a);
    @(negedge clk_i);
    bus = '{1'b1, 1'b0, a, 8'h00, 8'h00};
    @(negedge clk_i);
    bus.rd = 1'b0;
    d = rdata;
  endtask : rd

  // detector resets keep state, others reload
  task automatic do_reset(input logic [7:0] c, input logic det);
    @(negedge clk_i);
    cfg = c;
    det_rst_i = det;
    rst_b_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (2) @(negedge clk_i);
    det_rst_i = 1'b0;
  endtask : do_reset

  task automatic wait_irq();
    // skip a pulse already seen by the previous call
    @(negedge clk_i);
    for (int i = 0; i < 20 && irq !== 1'b1; i++)
      @(negedge clk_i);
    chk("irq", {7'h00, irq}, 8'h01);
    if (irq !== 1'b1)
      give_verdict();
  endtask : wait_irq

  initial
  begin
    rst_b_i = 1'b0;
    det_rst_i = 1'b0;
    cfg = 8'h7b;
    bus = '0;
    vdd = 16'd3300;
    mismatches = 0;
    n_tests = 0;
    // reset mode, range 011 fine 10; bit 4 always one
    do_reset(8'h7b, 1'b0);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h00);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h81);
    wr(SVD_ADDR_CTRL, 8'h80, 8'hff);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h00);
    wr(SVD_ADDR_LEVEL, 8'h00, 8'hff);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h81);
    vdd = 16'd2000;
    repeat (8) @(negedge clk_i);
    chk("int_rst", {7'h00, int_rst}, 8'h01);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h01);
    vdd = 16'd3300;
    repeat (8) @(negedge clk_i);
    chk("int_rst", {7'h00, int_rst}, 8'h00);
    // interrupt mode, irq on each crossing
    do_reset(8'h79, 1'b0);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h01);
    repeat (8) @(negedge clk_i);
    vdd = 16'd2000;
    wait_irq();
    vdd = 16'd3300;
    wait_irq();
    // interrupt-and-reset mode
    do_reset(8'h7a, 1'b0);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h00);
    wr(SVD_ADDR_CTRL, 8'h80, 8'h80);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h82);
    wr(SVD_ADDR_CTRL, 8'h01, 8'h01);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h82);
    do_reset(8'h7a, 1'b1);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h82);
    wr(SVD_ADDR_CTRL, 8'h00, 8'hff);
    repeat (10) @(negedge clk_i);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h00);
    vdd = 16'd2850;
    wait_irq();
    rd(SVD_ADDR_CTRL);
    chk("mask", {7'h00, d[1]}, 8'h01);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h81);
    repeat (12) @(negedge clk_i);
    chk("int_rst", {7'h00, int_rst}, 8'h01);
    vdd = 16'd3300;
    wr(SVD_ADDR_CTRL, 8'h80, 8'h80);
    wr(SVD_ADDR_LEVEL, 8'h00, 8'h80);
    rd(SVD_ADDR_LEVEL);
    chk("level", d, 8'h01);
    do_reset(8'h7a, 1'b0);
    rd(SVD_ADDR_CTRL);
    chk("ctrl", d, 8'h00);
    // detector off, external pin used
    vdd = 16'd2000;
    do_reset(8'h91, 1'b0);
    chk("ext", {7'h00, ext}, 8'h01);
    rd(SVD_ADDR_CTRL);
    chk("flag", {7'h00, d[0]}, 8'h00);
    give_verdict();
  end
endmodule : tb_top
